/* src/cms_pkg.sv */
/*
 package of the charging mode selector: control codes, code field positions,
 reset value, timing counts and the mode and limit enumerations.
 assumes a single 40 MHz reference clock.
*/
package cms_pkg;

   // reference clock
   localparam int unsigned CLK_HZ = 40_000_000;

   // full-speed qualification time, seconds
   localparam int unsigned FS_QUAL_SEC = 11;
   localparam int unsigned FS_QUAL_CYCLES = FS_QUAL_SEC * CLK_HZ;

   // output discharge pulse on a mode change, milliseconds
   localparam int unsigned DISCH_MS = 100;
   localparam int unsigned DISCH_CYCLES = DISCH_MS * ((CLK_HZ + 999) / 1000);

   // four-bit code {a, b, c, limit select}
   localparam int unsigned CODE_W = 4;
   localparam int unsigned CODE_SEL_BIT = 0;
   localparam int unsigned CODE_CTRL_LSB = 1;
   localparam int unsigned CODE_CTRL_MSB = 3;
   localparam logic [3:0] CODE_RESET = 4'h0;
   localparam logic [3:0] CODE_PW_AUTO = 4'h3;
   localparam logic [3:0] CODE_NPW_AUTO = 4'h7;
   localparam logic [3:0] CODE_STD_TWO = 4'hE;
   localparam logic [3:0] CODE_CDP = 4'hF;

   // three-bit control field {a, b, c}
   localparam logic [2:0] CTRL_DISCH = 3'h0;
   localparam logic [2:0] CTRL_AUTO = 3'h1;
   localparam logic [2:0] CTRL_STD_ONE_W = 3'h2;
   localparam logic [2:0] CTRL_AUTO_W = 3'h3;
   localparam logic [2:0] CTRL_SHORTED = 3'h4;
   localparam logic [2:0] CTRL_DIVIDER = 3'h5;
   localparam logic [2:0] CTRL_STD_ONE = 3'h6;
   localparam logic [2:0] CTRL_STD_TWO = 3'h7;

   // synchronised pin vector positions
   localparam int unsigned PIN_W = 9;
   localparam int unsigned PIN_SEL = 0;
   localparam int unsigned PIN_C = 1;
   localparam int unsigned PIN_B = 2;
   localparam int unsigned PIN_A = 3;
   localparam int unsigned PIN_DP = 4;
   localparam int unsigned PIN_DM = 5;
   localparam int unsigned PIN_PW = 6;
   localparam int unsigned PIN_NPW = 7;
   localparam int unsigned PIN_BC = 8;

   typedef enum logic [2:0] {
      CMS_DISCHARGE,
      CMS_AUTO_DEDICATED,
      CMS_STD_ONE,
      CMS_SHORTED,
      CMS_DIVIDER,
      CMS_STD_TWO,
      CMS_CDP
   } cms_mode_t;

   typedef enum logic [1:0] {
      CMS_LIM_NONE,
      CMS_LIM_LOW,
      CMS_LIM_HIGH,
      CMS_LIM_PW
   } cms_limit_t;

endpackage

/* src/cms_hid_detect.sv */
/*
 attach recogniser for low- and full-speed human-interface devices on the
 data lines. assumes dp_high and dm_high are already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cms_hid_detect
   import cms_pkg::*;
#(
   parameter int unsigned QUAL_CYC = FS_QUAL_CYCLES
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic detect_en,
   // data line levels
   input wire logic dp_high,
   input wire logic dm_high,
   // results
   output logic hid_ok,
   output logic high_speed
);

   if (QUAL_CYC < 2)
   begin : g_bad_param
      $error("qualification count out of range");
   end

   typedef enum logic [2:0] {
      HD_IDLE,
      HD_LOW_SPEED,
      HD_FS_WAIT,
      HD_FULL_SPEED,
      HD_HIGH_SPEED
   } cms_hd_state_t;

   localparam logic [31:0] QUAL_LAST = 32'(QUAL_CYC - 1);

   cms_hd_state_t state_reg, state_next;
   logic [31:0] cnt_reg, cnt_next;
   wire qual_done = (cnt_reg == QUAL_LAST);
   wire lines_low = !dp_high && !dm_high;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         HD_IDLE:
            if (dm_high && !dp_high)
               state_next = HD_LOW_SPEED;
            else if (dp_high && !dm_high)
               state_next = HD_FS_WAIT;
         HD_LOW_SPEED:
            if (lines_low)
               state_next = HD_IDLE;
         HD_FS_WAIT:
            if (!dp_high)
               state_next = HD_HIGH_SPEED;
            else if (qual_done)
               state_next = HD_FULL_SPEED;
         HD_FULL_SPEED:
            if (lines_low)
               state_next = HD_IDLE;
         HD_HIGH_SPEED:
            state_next = HD_HIGH_SPEED;
         default:
            state_next = HD_IDLE;
      endcase
      if (!detect_en)
         state_next = HD_IDLE;
   end

   assign cnt_next = (state_next == HD_FS_WAIT && state_reg == HD_FS_WAIT) ?
                     cnt_reg + 32'h1 : 32'h0;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= HD_IDLE;
         cnt_reg <= 32'h0;
         hid_ok <= 1'b0;
         high_speed <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         hid_ok <= (state_next == HD_LOW_SPEED) || (state_next == HD_FULL_SPEED);
         high_speed <= (state_next == HD_HIGH_SPEED);
      end
   end

   property p_detect_gate;
      @(posedge ref_clk) disable iff (!resetn)
      !detect_en |=> !hid_ok && state_reg == HD_IDLE;
   endproperty
   a_detect_gate: assert property (p_detect_gate) else $error("detection outside port modes");

   property p_low_speed_now;
      @(posedge ref_clk) disable iff (!resetn)
      state_reg == HD_IDLE && detect_en && dm_high && !dp_high |=> hid_ok;
   endproperty
   a_low_speed_now: assert property (p_low_speed_now) else $error("low-speed not taken at once");

   property p_no_device;
      @(posedge ref_clk) disable iff (!resetn)
      state_reg == HD_IDLE && lines_low |=> !hid_ok && state_reg == HD_IDLE;
   endproperty
   a_no_device: assert property (p_no_device) else $error("idle lines seen as device");

   property p_fs_candidate;
      @(posedge ref_clk) disable iff (!resetn)
      state_reg == HD_IDLE && detect_en && dp_high && !dm_high
         |=> state_reg == HD_FS_WAIT ##1 !hid_ok;
   endproperty
   a_fs_candidate: assert property (p_fs_candidate) else $error("full-speed candidate missed");

   property p_hs_fall;
      @(posedge ref_clk) disable iff (!resetn)
      state_reg == HD_FS_WAIT && detect_en && !dp_high |=> high_speed && !hid_ok;
   endproperty
   a_hs_fall: assert property (p_hs_fall) else $error("D+ fall not marked high speed");

   property p_fs_time;
      @(posedge ref_clk) disable iff (!resetn)
      $rose(hid_ok) && $past(state_reg) == HD_FS_WAIT |-> $past(cnt_reg) == QUAL_LAST;
   endproperty
   a_fs_time: assert property (p_fs_time) else $error("full-speed qualified early");

endmodule
`default_nettype wire

/* src/cms_mode_select.sv */
/*
 charging mode selector: decodes the control pins into a charging mode,
 current limit, data switch, discharge and load status, with wake override.
 assumes all pins are asynchronous to ref_clk and resetn follows power-on.
*/
`timescale 1ns/1ps
`default_nettype none
module cms_mode_select
   import cms_pkg::*;
#(
   parameter int unsigned DISCH_CYC = DISCH_CYCLES,
   parameter int unsigned FS_QUAL_CYC = FS_QUAL_CYCLES
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control pins
   input wire logic mode_ctrl_a,
   input wire logic mode_ctrl_b,
   input wire logic mode_ctrl_c,
   input wire logic limit_select,
   // data line level sense
   input wire logic dp_high,
   input wire logic dm_high,
   // load detect comparators
   input wire logic pw_load_present,
   input wire logic npw_load_present,
   input wire logic bc_primary_detect,
   // mode outputs
   output var cms_mode_t mode_out,
   output var cms_limit_t limit_out,
   output logic data_switch_en,
   output logic discharge_en,
   output logic load_detect_en,
   output logic load_status_n,
   // wake status
   output logic hid_wake_ok,
   output logic hid_high_speed
);

   if (DISCH_CYC < 1 || FS_QUAL_CYC < 2)
   begin : g_bad_param
      $error("cycle counts out of range");
   end

   localparam logic [31:0] DISCH_LOAD = 32'(DISCH_CYC);

   // pin synchronisers
   logic [PIN_W-1:0] sync1_reg, sync2_reg;
   wire [PIN_W-1:0] pins_raw = {bc_primary_detect, npw_load_present,
                                pw_load_present, dm_high, dp_high,
                                mode_ctrl_a, mode_ctrl_b, mode_ctrl_c,
                                limit_select};

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
      end
   end

   wire dp_s = sync2_reg[PIN_DP];
   wire dm_s = sync2_reg[PIN_DM];
   wire pw_s = sync2_reg[PIN_PW];
   wire npw_s = sync2_reg[PIN_NPW];
   wire bc_s = sync2_reg[PIN_BC];

   // commanded code from the pins alone
   wire [CODE_W-1:0] pin_code = sync2_reg[PIN_A:PIN_SEL];

   // held code with wake override
   logic [CODE_W-1:0] code_reg;
   logic [CODE_W-1:0] code_next;
   logic hid_ok;

   wire [2:0] held_ctrl = code_reg[CODE_CTRL_MSB:CODE_CTRL_LSB];
   wire [2:0] new_ctrl = pin_code[CODE_CTRL_MSB:CODE_CTRL_LSB];
   wire held_sel = code_reg[CODE_SEL_BIT];

   wire held_port = (held_ctrl == CTRL_STD_TWO) ||
                    (held_ctrl == CTRL_STD_ONE) ||
                    (held_ctrl == CTRL_STD_ONE_W);

   wire wake_hold = hid_ok && held_port && (new_ctrl == CTRL_AUTO_W);

   assign code_next = wake_hold ? code_reg : pin_code;

   // discharge on a mode change, except between 1111 and 1110
   wire code_change = (code_next != code_reg);
   wire cdp_pair = ((code_reg == CODE_CDP) && (code_next == CODE_STD_TWO)) ||
                   ((code_reg == CODE_STD_TWO) && (code_next == CODE_CDP));
   wire disch_start = code_change && !cdp_pair;

   logic [31:0] disch_cnt_reg;
   logic [31:0] disch_cnt_next;
   wire disch_busy = (disch_cnt_reg != 32'h0);

   assign disch_cnt_next = disch_start ? DISCH_LOAD :
                           disch_busy ? disch_cnt_reg - 32'h1 : 32'h0;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         code_reg <= CODE_RESET;
         disch_cnt_reg <= 32'h0;
      end
      else
      begin
         code_reg <= code_next;
         disch_cnt_reg <= disch_cnt_next;
      end
   end

   // attach recogniser runs only in port modes
   cms_hid_detect #(
      .QUAL_CYC(FS_QUAL_CYC)
   ) u_hid (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .detect_en(held_port),
      .dp_high(dp_s),
      .dm_high(dm_s),
      .hid_ok(hid_ok),
      .high_speed(hid_high_speed)
   );

   assign hid_wake_ok = hid_ok;

   // mode and limit decode
   cms_mode_t mode_dec;
   cms_limit_t limit_dec;
   wire cms_limit_t sel_limit = held_sel ? CMS_LIM_HIGH : CMS_LIM_LOW;

   always_comb
   begin
      mode_dec = CMS_DISCHARGE;
      limit_dec = CMS_LIM_NONE;
      case (held_ctrl)
         CTRL_DISCH:
         begin
            mode_dec = CMS_DISCHARGE;
            limit_dec = CMS_LIM_NONE;
         end
         CTRL_AUTO:
         begin
            mode_dec = CMS_AUTO_DEDICATED;
            if (held_sel && !pw_s)
               limit_dec = CMS_LIM_PW;
            else
               limit_dec = CMS_LIM_HIGH;
         end
         CTRL_AUTO_W:
         begin
            mode_dec = CMS_AUTO_DEDICATED;
            limit_dec = CMS_LIM_HIGH;
         end
         CTRL_STD_ONE_W, CTRL_STD_ONE:
         begin
            mode_dec = CMS_STD_ONE;
            limit_dec = sel_limit;
         end
         CTRL_SHORTED:
         begin
            mode_dec = CMS_SHORTED;
            limit_dec = sel_limit;
         end
         CTRL_DIVIDER:
         begin
            mode_dec = CMS_DIVIDER;
            limit_dec = sel_limit;
         end
         CTRL_STD_TWO:
         begin
            mode_dec = held_sel ? CMS_CDP : CMS_STD_TWO;
            limit_dec = sel_limit;
         end
         default:
         begin
            mode_dec = CMS_DISCHARGE;
            limit_dec = CMS_LIM_NONE;
         end
      endcase
   end

   // discharge, switch and load status decode
   wire disch_now = (held_ctrl == CTRL_DISCH) || disch_busy;
   wire cms_limit_t limit_now = disch_now ? CMS_LIM_NONE : limit_dec;
   wire switch_now = held_port && !disch_now;
   wire detect_now = (code_reg == CODE_PW_AUTO) ||
                     (code_reg == CODE_NPW_AUTO) ||
                     (code_reg == CODE_CDP);
   wire load_seen = ((code_reg == CODE_PW_AUTO) && pw_s) ||
                    ((code_reg == CODE_NPW_AUTO) && npw_s) ||
                    ((code_reg == CODE_CDP) && (npw_s || bc_s));
   wire status_n_now = !load_seen;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_out <= CMS_DISCHARGE;
         limit_out <= CMS_LIM_NONE;
         data_switch_en <= 1'b0;
         discharge_en <= 1'b1;
         load_detect_en <= 1'b0;
         load_status_n <= 1'b1;
      end
      else
      begin
         mode_out <= mode_dec;
         limit_out <= limit_now;
         data_switch_en <= switch_now;
         discharge_en <= disch_now;
         load_detect_en <= detect_now;
         load_status_n <= status_n_now;
      end
   end

   property p_follow;
      @(posedge ref_clk) disable iff (!resetn)
      !wake_hold |=> code_reg == $past(pin_code);
   endproperty
   a_follow: assert property (p_follow) else $error("commanded code not taken");

   property p_wake_hold;
      @(posedge ref_clk) disable iff (!resetn)
      hid_ok && held_port && new_ctrl == CTRL_AUTO_W
         |=> code_reg == $past(code_reg) ##1 data_switch_en == !$past(disch_busy);
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake override lost");

   property p_cdp_pair;
      @(posedge ref_clk) disable iff (!resetn)
      cdp_pair && !disch_busy |=> !disch_busy ##1 !discharge_en;
   endproperty
   a_cdp_pair: assert property (p_cdp_pair) else $error("discharge between 1111 and 1110");

   property p_disch_pulse;
      @(posedge ref_clk) disable iff (!resetn)
      disch_start |=> disch_busy ##1 discharge_en && !data_switch_en;
   endproperty
   a_disch_pulse: assert property (p_disch_pulse) else $error("mode change without discharge");

   property p_cdp_mode;
      @(posedge ref_clk) disable iff (!resetn)
      code_reg == CODE_CDP && !disch_busy |=>
         data_switch_en && limit_out == CMS_LIM_HIGH && load_detect_en;
   endproperty
   a_cdp_mode: assert property (p_cdp_mode) else $error("charging port setup wrong");

   property p_cdp_status;
      @(posedge ref_clk) disable iff (!resetn)
      code_reg == CODE_CDP && (bc_s || npw_s) |=> !load_status_n;
   endproperty
   a_cdp_status: assert property (p_cdp_status) else $error("charging port status missed");

   property p_auto_load;
      @(posedge ref_clk) disable iff (!resetn)
      code_reg == CODE_PW_AUTO && pw_s |=>
         !load_status_n && !data_switch_en && limit_out != CMS_LIM_PW;
   endproperty
   a_auto_load: assert property (p_auto_load) else $error("auto load status wrong");

   property p_pw_limit;
      @(posedge ref_clk) disable iff (!resetn)
      code_reg == CODE_PW_AUTO && !pw_s && !disch_busy |=> limit_out == CMS_LIM_PW;
   endproperty
   a_pw_limit: assert property (p_pw_limit) else $error("power-wake limit not applied");

   property p_std_limit;
      @(posedge ref_clk) disable iff (!resetn)
      mode_dec == CMS_STD_ONE && !disch_busy |=>
         limit_out == ($past(held_sel) ? CMS_LIM_HIGH : CMS_LIM_LOW) && data_switch_en;
   endproperty
   a_std_limit: assert property (p_std_limit) else $error("standard port limit wrong");

   property p_forced;
      @(posedge ref_clk) disable iff (!resetn)
      held_ctrl == CTRL_SHORTED |=> mode_out == CMS_SHORTED && load_status_n && !data_switch_en;
   endproperty
   a_forced: assert property (p_forced) else $error("forced shorted mode wrong");

   property p_divider;
      @(posedge ref_clk) disable iff (!resetn)
      held_ctrl == CTRL_DIVIDER |=> mode_out == CMS_DIVIDER && load_status_n && !data_switch_en;
   endproperty
   a_divider: assert property (p_divider) else $error("forced divider mode wrong");

   property p_discharge;
      @(posedge ref_clk) disable iff (!resetn)
      held_ctrl == CTRL_DISCH |=> discharge_en && !data_switch_en && load_status_n;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge mode wrong");

   property p_no_detect;
      @(posedge ref_clk) disable iff (!resetn)
      !detect_now |=> load_status_n && !load_detect_en;
   endproperty
   a_no_detect: assert property (p_no_detect) else $error("status low without detection");

   property p_npw_status;
      @(posedge ref_clk) disable iff (!resetn)
      code_reg == CODE_NPW_AUTO && npw_s |=>
         !load_status_n && load_detect_en && !data_switch_en;
   endproperty
   a_npw_status: assert property (p_npw_status) else $error("auto status wrong on 0111");

   property p_auto_open;
      @(posedge ref_clk) disable iff (!resetn)
      held_ctrl == CTRL_AUTO_W && !disch_busy |=>
         mode_out == CMS_AUTO_DEDICATED && limit_out == CMS_LIM_HIGH && !data_switch_en;
   endproperty
   a_auto_open: assert property (p_auto_open) else $error("commanded auto mode not set");

endmodule
`default_nettype wire

/* sim/cms_ctrl_model.sv */
/*
 model of the system power controller that drives the four control pins.
 assumes the caller changes the setting just after a ref_clk rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cms_ctrl_model
   import cms_pkg::*;
(
   // control pins toward the selector
   output logic mode_ctrl_a,
   output logic mode_ctrl_b,
   output logic mode_ctrl_c,
   output logic limit_select
);
   logic [CODE_W-1:0] code_reg;

   // pins are plain static levels of the held code
   assign {mode_ctrl_a, mode_ctrl_b, mode_ctrl_c, limit_select} = code_reg;

   initial code_reg = CODE_RESET;

   // new setting at any time, wake or not; caller holds port mode past qualification
   task automatic drive(input logic [3:0] code);
      code_reg = code;
   endtask
endmodule
`default_nettype wire

/* sim/charge_mode_select_hid_detect_tb.sv */
/*
 self-checking bench of the charging mode selector: code table, discharge,
 wake override and attach recognition. assumes short parameter values.
*/
`timescale 1ns/1ps
`default_nettype none
module charge_mode_select_hid_detect_tb;
   import cms_pkg::*;
   logic ref_clk, resetn, dp_high, dm_high, pw, npw, bc;
   logic ca, cb, cc, sel, sw, dis, ldet, stat_n, hid, hs;
   cms_mode_t mode_out;
   cms_limit_t limit_out;
   int fail_count = 0;
   int n_checks = 0;

   cms_ctrl_model u_cms_ctrl_model (.mode_ctrl_a(ca), .mode_ctrl_b(cb),
      .mode_ctrl_c(cc), .limit_select(sel));

   cms_mode_select #(.DISCH_CYC(4), .FS_QUAL_CYC(20)) u_cms_mode_select (
      .ref_clk(ref_clk), .resetn(resetn), .mode_ctrl_a(ca), .mode_ctrl_b(cb),
      .mode_ctrl_c(cc), .limit_select(sel), .dp_high(dp_high), .dm_high(dm_high),
      .pw_load_present(pw), .npw_load_present(npw), .bc_primary_detect(bc),
      .mode_out(mode_out), .limit_out(limit_out), .data_switch_en(sw),
      .discharge_en(dis), .load_detect_en(ldet), .load_status_n(stat_n),
      .hid_wake_ok(hid), .hid_high_speed(hs));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   // new code, then wait past sync, code, discharge and output stages
   task automatic set(input logic [3:0] c);
      u_cms_ctrl_model.drive(c);
      cyc(16);
   endtask

   // expected {mode, limit, switch, detect, status_n} of a code
   function automatic logic [7:0] exp_out(input logic [3:0] c, input logic ld);
      cms_mode_t m;
      cms_limit_t l;
      logic s, d;
      case (c[3:1])
         3'h0: m = CMS_DISCHARGE;
         3'h1, 3'h3: m = CMS_AUTO_DEDICATED;
         3'h2, 3'h6: m = CMS_STD_ONE;
         3'h4: m = CMS_SHORTED;
         3'h5: m = CMS_DIVIDER;
         default: m = c[0] ? CMS_CDP : CMS_STD_TWO;
      endcase
      s = (m == CMS_STD_ONE) || (m == CMS_STD_TWO) || (m == CMS_CDP);
      d = (c == 4'h3) || (c == 4'h7) || (c == 4'hF);
      l = (m == CMS_DISCHARGE) ? CMS_LIM_NONE :
          (m == CMS_AUTO_DEDICATED) ? ((c == 4'h3 && !ld) ? CMS_LIM_PW : CMS_LIM_HIGH) :
          (c[0] ? CMS_LIM_HIGH : CMS_LIM_LOW);
      return {m, l, s, d, !(d && ld)};
   endfunction

   task automatic chk_out(input logic [3:0] c, input logic ld);
      logic [7:0] e;
      e = exp_out(c, ld);
      chk("mode", 4'(mode_out), {1'b0, e[7:5]});
      chk("limit", 4'(limit_out), {2'h0, e[4:3]});
      chk("switch", {3'h0, sw}, {3'h0, e[2]});
      chk("detect", {3'h0, ldet}, {3'h0, e[1]});
      chk("status_n", {3'h0, stat_n}, {3'h0, e[0]});
      chk("discharge", {3'h0, dis}, {3'h0, c[3:1] == 3'h0});
   endtask

   // watch a change cycle by cycle for any discharge or switch drop
   task automatic watch(input logic [3:0] c, input logic ed);
      logic ds, so;
      ds = 1'b0;
      so = 1'b0;
      u_cms_ctrl_model.drive(c);
      repeat (14)
      begin
         cyc(1);
         if (dis !== 1'b0)
            ds = 1'b1;
         if (sw !== 1'b1)
            so = 1'b1;
      end
      chk("disch_seen", {3'h0, ds}, {3'h0, ed});
      chk("switch_drop", {3'h0, so}, {3'h0, ed});
   endtask

   // low-speed device held, then a move to 011 must be ignored until it leaves
   task automatic ovr(input logic [3:0] from, input logic [3:0] to, input cms_mode_t m0);
      set(from);
      dm_high = 1'b1;
      cyc(6);
      chk("ls_wake", {3'h0, hid}, 4'h1);
      set(to);
      chk("held_mode", 4'(mode_out), 4'(m0));
      chk("held_switch", {3'h0, sw}, 4'h1);
      dm_high = 1'b0;
      cyc(16);
      chk("ls_gone", {3'h0, hid}, 4'h0);
      chk("auto_mode", 4'(mode_out), 4'(CMS_AUTO_DEDICATED));
   endtask

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      stop_test();
   end

   initial
   begin
      resetn = 1'b0;
      {dp_high, dm_high, pw, npw, bc} = 5'h00;
      cyc(8);
      chk_out(4'h0, 1'b0);
      resetn = 1'b1;
      for (int ld = 0; ld < 2; ld++)
      begin
         {pw, npw} = {2{ld[0]}};
         bc = ld[0];
         for (int c = 0; c < 16; c++)
         begin
            set(c[3:0]);
            chk_out(c[3:0], ld[0]);
         end
      end
      {pw, npw} = 2'h0;
      cyc(4);
      chk("bc_status_n", {3'h0, stat_n}, 4'h0);
      bc = 1'b0;
      watch(4'hE, 1'b0);
      watch(4'hF, 1'b0);
      watch(4'hD, 1'b1);
      set(4'h2);
      dm_high = 1'b1;
      cyc(8);
      chk("no_detect", {3'h0, hid}, 4'h0);
      dm_high = 1'b0;
      ovr(4'hC, 4'h6, CMS_STD_ONE);
      ovr(4'hF, 4'h7, CMS_CDP);
      ovr(4'h4, 4'h7, CMS_STD_ONE);
      set(4'hF);
      dp_high = 1'b1;
      cyc(15);
      chk("fs_early", {3'h0, hid}, 4'h0);
      cyc(15);
      chk("fs_wake", {3'h0, hid}, 4'h1);
      chk("fs_not_hs", {3'h0, hs}, 4'h0);
      dp_high = 1'b0;
      cyc(6);
      chk("fs_gone", {3'h0, hid}, 4'h0);
      set(4'h2);
      set(4'hE);
      dp_high = 1'b1;
      cyc(5);
      dp_high = 1'b0;
      cyc(6);
      chk("hs_flag", {3'h0, hs}, 4'h1);
      dp_high = 1'b1;
      cyc(40);
      chk("hs_no_wake", {3'h0, hid}, 4'h0);
      stop_test();
   end
endmodule
`default_nettype wire
